// ==== core/brc_pkg.sv ====
// brc_pkg: constants for the bidirectional reset control block
package brc_pkg;
  // ---------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] BRC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] BRC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] BRC_ADDR_IRQ    = 8'h08;
  localparam logic [7:0] BRC_ADDR_MASK   = 8'h0C;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BRC_CTRL_ENABLE   = 0;
  localparam int BRC_CTRL_END_OF_INIT_INSTRUCTION    = 1;
  localparam int BRC_CTRL_SWRST    = 2;
  localparam int BRC_ST_LONG_HW    = 0;
  localparam int BRC_ST_LOCKED     = 1;
  localparam int BRC_ST_BOOTLDR    = 2;
  localparam int BRC_ST_SEQ_BUSY   = 3;
  localparam int BRC_IRQ_STRETCHED = 0;
  localparam int BRC_IRQ_LOCKWRITE = 1;
  localparam int BRC_IRQ_DONE      = 2;
  localparam int BRC_IRQ_W         = 3;
  localparam int BRC_BOOT_SEL_BIT  = 4;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] BRC_IRQ_MASK_RST = 3'h0;
  localparam int BRC_CLK_HZ        = 40000000;
  localparam int BRC_SEQ_TIME_NS   = 25600;
  localparam int BRC_SEQ_CYCLES    = (BRC_SEQ_TIME_NS * (BRC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int BRC_CNT_W         = 12;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BRC_IDLE  = 2'b00,
    BRC_SEQ   = 2'b01,
    BRC_WAIT  = 2'b10
  } brc_state_t;
endpackage : brc_pkg

// ==== core/brc_sync.sv ====
// brc_sync: two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module brc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // brc_sync
`default_nettype wire

// ==== core/brc_top.sv ====
// brc_top: bidirectional reset control with apb registers
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module brc_top
  import brc_pkg::*;
#(
  parameter int SEQ_CYCLES = brc_pkg::BRC_SEQ_CYCLES,
  parameter int BOOT_W     = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              reset_input_pin_in,
  output logic                   reset_input_pin_out,
  output logic                   reset_input_pin_oe,
  input  wire logic [BOOT_W-1:0] boot_config_port,
  output logic [BOOT_W-1:0]      boot_config,
  output logic                   bootstrap_mode,
  output logic                   long_hw_reset_flag,
  output logic                   core_reset_b,
  output logic                   irq
);
  import brc_pkg::*;
  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic              rst_meta_b;
  logic              rst_sync_b;
  logic              pin_sync;
  logic [BOOT_W-1:0] boot_sync;
  logic [BOOT_W:0]   sync_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end
  brc_sync #(.W(1 + BOOT_W)) u_sync (
    .mclk  (mclk),
    .rst_b (rst_sync_b),
    .ce    (ce),
    .d     ({!reset_input_pin_in, boot_config_port}),
    .q     (sync_q)
  );
  // pin passes inverted so a cleared synchroniser reads an idle high pin
  assign pin_sync  = !sync_q[BOOT_W];
  assign boot_sync = sync_q[BOOT_W-1:0];
  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  brc_state_t           state;
  brc_state_t           next_state;
  logic                 bidir_reset_enable_bit;
  logic                 locked;
  logic                 pin_prev;
  logic [BRC_CNT_W-1:0] cnt;
  logic [BRC_IRQ_W-1:0] irq_status;
  logic [BRC_IRQ_W-1:0] irq_mask;
  logic                 stretched;
  logic                 pin_rel;
  wire access     = psel && penable && ce;
  wire wr         = access && pwrite;
  wire wr_ctrl    = wr && (paddr == BRC_ADDR_CTRL);
  wire wr_irq     = wr && (paddr == BRC_ADDR_IRQ);
  wire wr_mask    = wr && (paddr == BRC_ADDR_MASK);
  wire mapped     = (paddr == BRC_ADDR_CTRL) || (paddr == BRC_ADDR_STATUS)
                 || (paddr == BRC_ADDR_IRQ) || (paddr == BRC_ADDR_MASK);
  wire en_write   = wr_ctrl && !locked;
  wire lock_poke  = wr_ctrl && locked
                 && (pwdata[BRC_CTRL_ENABLE] != bidir_reset_enable_bit);
  wire do_end_of_init_instruction   = wr_ctrl && pwdata[BRC_CTRL_END_OF_INIT_INSTRUCTION];
  wire sw_reset   = wr_ctrl && pwdata[BRC_CTRL_SWRST];
  wire pin_fall   = pin_prev && !pin_sync;
  wire seq_start  = (state == BRC_IDLE) && (pin_fall || sw_reset);
  wire seq_last   = (state == BRC_SEQ) && (cnt == BRC_CNT_W'(SEQ_CYCLES - 1));
  wire stretched_next = seq_start ? bidir_reset_enable_bit : stretched;
  // a short pulse ended before the sequence did: stretching happened; our own
  // pull hides a pulse that outlasts the start of the drive, which then reads as long
  wire short_seen = seq_last && (pin_sync || pin_rel);
  wire [BRC_IRQ_W-1:0] irq_set = {seq_last, lock_poke, short_seen && stretched};
  wire [31:0] status_word = {28'h0, state != BRC_IDLE, bootstrap_mode, locked,
                             long_hw_reset_flag};
  wire [31:0] rd_mux =
      (paddr == BRC_ADDR_CTRL)   ? {31'h0, bidir_reset_enable_bit} :
      (paddr == BRC_ADDR_STATUS) ? status_word :
      (paddr == BRC_ADDR_IRQ)    ? {29'h0, irq_status} :
      (paddr == BRC_ADDR_MASK)   ? {29'h0, irq_mask} : 32'h0;
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      BRC_IDLE: if (seq_start) next_state = BRC_SEQ;
      BRC_SEQ:  if (seq_last) next_state = pin_sync ? BRC_IDLE : BRC_WAIT;
      BRC_WAIT: if (pin_sync) next_state = BRC_IDLE;
      default:  next_state = BRC_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state    <= BRC_SEQ;
      cnt      <= '0;
      pin_prev <= 1'b1;
      pin_rel  <= 1'b0;
    end else if (ce) begin
      state    <= next_state;
      pin_prev <= pin_sync;
      pin_rel  <= seq_start ? 1'b0 : (pin_rel || (state == BRC_SEQ && pin_sync));
      cnt      <= (state == BRC_SEQ && !seq_last) ? cnt + 1'b1 : '0;
    end
  end
  // ---------------------------------------------------------------
  // enable bit, lock and reset results
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bidir_reset_enable_bit <= 1'b0;
      locked                 <= 1'b0;
    end else if (ce) begin
      if (seq_start) begin
        bidir_reset_enable_bit <= 1'b0;
        locked                 <= 1'b0;
      end else begin
        if (en_write) bidir_reset_enable_bit <= pwdata[BRC_CTRL_ENABLE];
        if (do_end_of_init_instruction) locked <= 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stretched           <= 1'b0;
      long_hw_reset_flag  <= 1'b0;
      boot_config         <= '0;
      bootstrap_mode      <= 1'b0;
    end else if (ce && seq_start) begin
      stretched <= bidir_reset_enable_bit;
    end else if (ce && seq_last) begin
      long_hw_reset_flag <= stretched || !pin_sync;
      if (stretched) begin
        boot_config    <= boot_sync;
        bootstrap_mode <= !boot_sync[BRC_BOOT_SEL_BIT];
      end
    end
  end
  // ---------------------------------------------------------------
  // pin and core reset drive
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reset_input_pin_out <= 1'b0;
      reset_input_pin_oe  <= 1'b0;
      core_reset_b        <= 1'b0;
    end else if (ce) begin
      reset_input_pin_oe  <= (next_state == BRC_SEQ) && stretched_next;
      reset_input_pin_out <= 1'b0;
      core_reset_b        <= (next_state == BRC_IDLE);
    end
  end
  // ---------------------------------------------------------------
  // interrupts and apb
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_status <= '0;
      irq_mask   <= BRC_IRQ_MASK_RST;
      irq        <= 1'b0;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else if (ce) begin
      irq_status <= (irq_status & ~(wr_irq ? pwdata[BRC_IRQ_W-1:0] : '0)) | irq_set;
      if (wr_mask) irq_mask <= pwdata[BRC_IRQ_W-1:0];
      irq        <= |(irq_status & irq_mask);
      pready     <= psel && !penable;
      pslverr    <= psel && !penable && !mapped;
      prdata     <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_lock_holds_enable: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (ce && locked && !seq_start) |=> $stable(bidir_reset_enable_bit))
    else $error("enable bit changed while locked");
  a_reset_clears_en: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (ce && seq_start) |=> !bidir_reset_enable_bit && !locked)
    else $error("enable bit survived reset");
  a_long_flag: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (ce && seq_last && stretched) |=> long_hw_reset_flag)
    else $error("long reset flag not set");
  a_boot_select: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (ce && seq_last && stretched && !boot_sync[BRC_BOOT_SEL_BIT]) |=> bootstrap_mode)
    else $error("bootstrap not entered");
  a_stretch_core: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (ce && seq_start) |=> !core_reset_b)
    else $error("core reset not held");
  a_pin_driven: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (ce && seq_start && bidir_reset_enable_bit) |=> reset_input_pin_oe && !reset_input_pin_out)
    else $error("reset pin not driven low");
  c_stretch: cover property (@(posedge mclk) disable iff (!rst_sync_b) irq_set[BRC_IRQ_STRETCHED]);
  c_lock_poke: cover property (@(posedge mclk) disable iff (!rst_sync_b) lock_poke);
  c_boot: cover property (@(posedge mclk) disable iff (!rst_sync_b) $rose(bootstrap_mode));
  c_wait_pin: cover property (@(posedge mclk) disable iff (!rst_sync_b) state == BRC_WAIT);
  c_sw_reset: cover property (@(posedge mclk) disable iff (!rst_sync_b) sw_reset && seq_start);
endmodule // brc_top
`default_nettype wire

// ==== verif/brc_ext_rst_dev.sv ====
// brc_ext_rst_dev: external reset device with an open-drain output
`timescale 1ns/1ps
`default_nettype none
module brc_ext_rst_dev (
  input  wire logic       mclk,
  input  wire logic       start,
  input  wire logic [7:0] len,
  input  wire logic       dev_oe,
  output logic            pin
);
  logic [7:0] cnt = 8'h00;
  always @(posedge mclk) begin
    if (start)
      cnt <= len;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  // pull-up: the pin is low while either party pulls it
  assign pin = !((cnt != 8'h00) || dev_oe);
endmodule // brc_ext_rst_dev
`default_nettype wire

// ==== verif/tb_top.sv ====
// tb_top: register level tests of the bidirectional reset control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import brc_pkg::*;
  localparam int SEQ = 8;
  logic        mclk = 1'b0, rst_b = 1'b0, start = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, len = 8'h00, boot = 8'hFF, bcfg;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, pin, oe, pout, bmode, lflag, core_b, irq;
  int          fails = 0, n_tests = 0, lo;
  initial forever #12.5 mclk = ~mclk;
  brc_top #(.SEQ_CYCLES(SEQ)) u_brc_top (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_input_pin_in(pin),
    .reset_input_pin_out(pout), .reset_input_pin_oe(oe), .boot_config_port(boot),
    .boot_config(bcfg), .bootstrap_mode(bmode), .long_hw_reset_flag(lflag),
    .core_reset_b(core_b), .irq(irq));
  brc_ext_rst_dev u_brc_ext_rst_dev (.mclk(mclk), .start(start), .len(len),
    .dev_oe(oe), .pin(pin));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_core(input logic v);
    lo = 0;
    while (core_b !== v && lo < 200) begin
      @(posedge mclk);
      lo++;
    end
    chk(lo < 200, 1, "sequence end");
  endtask
  task automatic irq_wait(input logic exp, input string m);
    repeat (2) @(posedge mclk);
    chk(irq, exp, m);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    wait_core(1'b1);
    apb(1'b0, BRC_ADDR_CTRL, 32'h0);
    chk(rd[0], 0, "enable after reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1, "unmapped error");
    for (int i = 0; i < 2; i++) begin
      boot <= (i == 0) ? 8'hEF : 8'h10;
      apb(1'b1, BRC_ADDR_CTRL, 32'h1);
      @(posedge mclk);
      start <= 1'b1;
      len <= (i == 0) ? 8'h02 : 8'h14;
      @(posedge mclk);
      start <= 1'b0;
      wait_core(1'b0);
      repeat (2) @(posedge mclk);
      chk(oe, 1, "pin pulled in sequence");
      chk(pout, 0, "pin driven low");
      wait_core(1'b1);
      chk(lo >= SEQ, 1, "reset stretched");
      chk(lflag, 1, "long reset flag");
      chk(bmode, (i == 0), "bootstrap select");
      chk(bcfg, boot, "boot port latch");
      repeat (2) @(posedge mclk);
      chk(oe, 0, "pin released");
      apb(1'b0, BRC_ADDR_CTRL, 32'h0);
      chk(rd[0], 0, "enable cleared");
      apb(1'b0, BRC_ADDR_IRQ, 32'h0);
      chk(rd[2:0], (i == 0) ? 3'h5 : 3'h4, "event flags");
      apb(1'b1, BRC_ADDR_MASK, 32'h0);
      irq_wait(1'b0, "irq masked");
      apb(1'b1, BRC_ADDR_MASK, 32'h7);
      irq_wait(1'b1, "irq raised");
      apb(1'b1, BRC_ADDR_IRQ, 32'h7);
      irq_wait(1'b0, "irq cleared");
      $display("reset pulse test %0d done", i);
    end
    apb(1'b1, BRC_ADDR_CTRL, 32'h3);
    apb(1'b1, BRC_ADDR_CTRL, 32'h0);
    apb(1'b0, BRC_ADDR_CTRL, 32'h0);
    chk(rd[0], 1, "enable locked");
    apb(1'b0, BRC_ADDR_STATUS, 32'h0);
    chk(rd[1], 1, "lock status");
    apb(1'b0, BRC_ADDR_IRQ, 32'h0);
    chk(rd[1], 1, "locked write event");
    apb(1'b1, BRC_ADDR_CTRL, 32'h4);
    wait_core(1'b0);
    ce <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(core_b, 0, "sequence frozen by clock enable");
    ce <= 1'b1;
    wait_core(1'b1);
    apb(1'b0, BRC_ADDR_CTRL, 32'h0);
    chk(rd[0], 0, "enable cleared by reset");
    $display("lock test done");
    summarize();
  end
  initial begin
    #500000;
    fails++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
